// >>> design/pes_pkg.sv
// Constants and types for the precise event sampling and load latency unit
package pes_pkg;

   // ***************************************************************
   // Register indices on the register port
   // ***************************************************************
   localparam logic [11:0] MSR_SAMPLING_ENABLE   = 12'h010;
   localparam logic [11:0] MSR_LATENCY_THRESHOLD = 12'h011;
   localparam logic [11:0] MSR_GLOBAL_STATUS     = 12'h012;
   localparam logic [11:0] MSR_OVF_CLEAR         = 12'h013;

   // ***************************************************************
   // Field positions and reset values
   // ***************************************************************
   localparam int          NUM_PREC_CTR    = 4;
   localparam int          NUM_GP_CTR      = 8;
   localparam int          SE_SAMPLE_LSB   = 0;
   localparam int          SE_LATENCY_LSB  = 32;
   localparam int          SE_PSTORE_BIT   = 63;
   localparam int          GS_BUF_OVF_BIT  = 62;
   localparam int          DS_SRC_W        = 4;
   localparam int          DS_STLB_BIT     = 4;
   localparam int          DS_LOCK_BIT     = 5;
   localparam int          ST_L1_HIT_BIT   = 0;
   localparam int          THR_W           = 16;
   localparam logic [63:0] SE_RESET        = 64'h0;
   localparam logic [15:0] THR_RESET       = 16'h0003;
   localparam logic [15:0] LFSR_SEED       = 16'hace1;
   localparam logic [1:0]  PSTORE_CTR      = 2'h3;
   localparam logic [1:0]  DISTRIB_CTR     = 2'h1;
   localparam int          FIFO_DEPTH      = 16;
   localparam int          REC_W           = 2 + 3 * 64;

   // ***************************************************************
   // Event selects and unit masks that may sample
   // ***************************************************************
   localparam logic [7:0]  EV_RET_INST   = 8'hc0;
   localparam logic [7:0]  EV_RET_UOP    = 8'hc2;
   localparam logic [7:0]  EV_RET_BRANCH = 8'hc4;
   localparam logic [7:0]  EV_MISPREDICT = 8'hc5;
   localparam logic [7:0]  EV_MEM_TRANS  = 8'hcd;
   localparam logic [7:0]  EV_MEM_UOP    = 8'hd0;
   localparam logic [7:0]  EV_LOAD_HIT   = 8'hd1;
   localparam logic [7:0]  EV_LLC_HIT    = 8'hd2;
   localparam logic [7:0]  EV_LOAD_MISC  = 8'hd4;
   localparam logic [15:0] LATENCY_EVENT = 16'h01cd;
   localparam logic [15:0] PSTORE_EVENT  = 16'h02cd;
   localparam logic [7:0]  UM_DISTRIB    = 8'h01;

   typedef enum logic [2:0] {
      LS_IDLE = 3'b001,
      LS_MEAS = 3'b010,
      LS_RET  = 3'b100
   } pes_ld_e;

endpackage

// >>> design/pes_fifo.sv
// Record FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pes_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_q[rd_q];

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// >>> design/pes_sampling.sv
// Precise event sampling unit with load latency tagging and record output
//
// Functional notes
// - Only counters zero to three may sample.
// - Bit 63 enables precise store on counter three.
// - Record 98H holds load or store linear address.
// - Record A0H holds data source or store status.
// - Record A8H holds latency, zero for stores.
// - Record write clears overflowed sampling-enabled status bits.
// - Only listed event codes and masks may sample.
// - Precise distribution mask 01H on counter one only.
// - Latency measured from dispatch to globally observed.
// - Count tagged retired loads above threshold, no stores.
// - Latency strictly above threshold counts; threshold at least 3 (the register keeps any 16-bit write, even below 3).
// - Randomly tag loads, update info, count retired.
// - Cancelled tagged load leaves state; tag next load.
// - Record carries last retired tagged load's info.
// - Reload value independent of tagging mechanism.
// - Source bits 3:0, translation miss 4, lock 5.
// - Store status: cache hit 0, miss 4, lock 5.
// - Record write clears status, sets buffer overflow flag.
`timescale 1ns/1ps
module pes_sampling #(
   parameter int DEPTH = pes_pkg::FIFO_DEPTH
) (
   input  wire logic                         core_clk_i,
   input  wire logic                         arst_n_i,
   input  wire logic                         msr_wr_i,
   input  wire logic                         msr_rd_i,
   input  wire logic [11:0]                  msr_addr_i,
   input  wire logic [63:0]                  msr_wdata_i,
   output logic      [63:0]                  msr_rdata_o,
   output logic                              msr_ack_o,
   input  wire logic [3:0][15:0]             event_select_i,
   input  wire logic [7:0]                   ctr_ovf_i,
   input  wire logic                         ld_disp_i,
   input  wire logic [3:0]                   ld_disp_id_i,
   input  wire logic                         ld_go_i,
   input  wire logic [3:0]                   ld_go_id_i,
   input  wire logic                         ld_cancel_i,
   input  wire logic [3:0]                   ld_cancel_id_i,
   input  wire logic                         ld_retire_i,
   input  wire logic [3:0]                   ld_retire_id_i,
   input  wire logic [63:0]                  ld_addr_i,
   input  wire logic [3:0]                   ld_src_i,
   input  wire logic                         ld_second_tlb_miss_i,
   input  wire logic                         ld_lock_i,
   input  wire logic                         st_retire_i,
   input  wire logic [63:0]                  st_addr_i,
   input  wire logic                         st_l1_hit_i,
   input  wire logic                         st_second_tlb_miss_i,
   input  wire logic                         st_lock_i,
   output logic      [3:0]                   latency_count_o,
   output logic      [63:0]                  global_status_o,
   output logic                              rec_valid_o,
   input  wire logic                         rec_ready_i,
   output logic      [1:0]                   rec_ctr_o,
   output logic      [63:0]                  rec_addr_o,
   output logic      [63:0]                  rec_src_o,
   output logic      [63:0]                  rec_lat_o
);

   // ***************************************************************
   // Registers and event qualification
   // ***************************************************************
   logic [63:0]               se_q;
   logic [pes_pkg::THR_W-1:0] thr_q;
   logic [7:0]                gs_ovf_q;
   logic                      gs_buf_q;
   logic [3:0]                samp_en;
   logic [3:0]                lat_en;
   logic                      ps_en;
   logic [3:0]                ev_ok;
   logic [3:0]                ll_ctr;

   assign samp_en = se_q[pes_pkg::SE_SAMPLE_LSB +: 4];
   assign lat_en  = se_q[pes_pkg::SE_LATENCY_LSB +: 4];
   assign ps_en   = se_q[pes_pkg::SE_PSTORE_BIT];

   function automatic logic event_ok(input logic [15:0] sel, input logic [1:0] ctr);
      logic [7:0] um;
      um = sel[15:8];
      case (sel[7:0])
         pes_pkg::EV_RET_INST:   event_ok = (um == pes_pkg::UM_DISTRIB)
                                            && (ctr == pes_pkg::DISTRIB_CTR);
         pes_pkg::EV_RET_UOP:    event_ok = (um == 8'h01) || (um == 8'h02);
         pes_pkg::EV_RET_BRANCH: event_ok = $onehot(um) && !um[7];
         pes_pkg::EV_MISPREDICT: event_ok = $onehot(um) && (um[7:6] == 2'h0) && !um[3];
         pes_pkg::EV_MEM_TRANS:  event_ok = (um == 8'h01) || (um == 8'h02);
         pes_pkg::EV_MEM_UOP:    event_ok = $onehot(um) && (um[3:2] == 2'h0);
         pes_pkg::EV_LOAD_HIT:   event_ok = $onehot(um) && !um[7] && (um[5:3] == 3'h0);
         pes_pkg::EV_LLC_HIT:    event_ok = $onehot(um) && (um[7:4] == 4'h0);
         pes_pkg::EV_LOAD_MISC:  event_ok = (um == 8'h02);
         default:                event_ok = 1'b0;
      endcase
   endfunction

   always_comb begin
      for (int i = 0; i < pes_pkg::NUM_PREC_CTR; i++) begin
         ev_ok[i]  = event_ok(event_select_i[i], 2'(i));
         ll_ctr[i] = samp_en[i] && lat_en[i]
                     && (event_select_i[i] == pes_pkg::LATENCY_EVENT);
      end
   end

   // ***************************************************************
   // Register port
   // ***************************************************************
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         se_q  <= pes_pkg::SE_RESET;
         thr_q <= pes_pkg::THR_RESET;
      end else if (msr_wr_i) begin
         if (msr_addr_i == pes_pkg::MSR_SAMPLING_ENABLE) begin
            se_q <= msr_wdata_i;
         end
         if (msr_addr_i == pes_pkg::MSR_LATENCY_THRESHOLD) begin
            thr_q <= msr_wdata_i[pes_pkg::THR_W-1:0];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         msr_rdata_o <= 64'h0;
         msr_ack_o   <= 1'b0;
      end else begin
         msr_ack_o <= msr_rd_i || msr_wr_i;
         if (msr_rd_i) begin
            case (msr_addr_i)
               pes_pkg::MSR_SAMPLING_ENABLE:   msr_rdata_o <= se_q;
               pes_pkg::MSR_LATENCY_THRESHOLD: msr_rdata_o <= 64'(thr_q);
               pes_pkg::MSR_GLOBAL_STATUS:     msr_rdata_o <= global_status_o;
               default:                        msr_rdata_o <= 64'h0;
            endcase
         end
      end
   end

   // ***************************************************************
   // Load tagging and latency measurement
   // ***************************************************************
   pes_pkg::pes_ld_e          ld_st_q;
   logic [3:0]                tag_id_q;
   logic [pes_pkg::THR_W-1:0] lat_q;
   logic [15:0]               lfsr_q;
   logic [63:0]               last_addr_q;
   logic [5:0]                last_src_q;
   logic [pes_pkg::THR_W-1:0] last_lat_q;
   logic                      tag_cancel;
   logic                      tag_retire;

   assign tag_cancel = ld_cancel_i && (ld_cancel_id_i == tag_id_q) && (ld_st_q != pes_pkg::LS_IDLE);
   assign tag_retire = ld_retire_i && (ld_retire_id_i == tag_id_q) && (ld_st_q == pes_pkg::LS_RET);

   // Free-running so the tag choice is not tied to program phase
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lfsr_q <= pes_pkg::LFSR_SEED;
      end else begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ld_st_q  <= pes_pkg::LS_IDLE;
         tag_id_q <= 4'h0;
         lat_q    <= '0;
      end else begin
         case (ld_st_q)
            pes_pkg::LS_IDLE: begin
               // After a cancel the next dispatched load is taken outright
               if (ld_disp_i && (|ll_ctr) && (lfsr_q[0] || lat_q[0])) begin
                  ld_st_q  <= pes_pkg::LS_MEAS;
                  tag_id_q <= ld_disp_id_i;
                  lat_q    <= '0;
               end
            end
            pes_pkg::LS_MEAS: begin
               if (tag_cancel) begin
                  ld_st_q <= pes_pkg::LS_IDLE;
                  lat_q   <= 16'h0001;
               end else if (ld_go_i && (ld_go_id_i == tag_id_q)) begin
                  ld_st_q <= pes_pkg::LS_RET;
                  lat_q   <= lat_q + 1'b1;
               end else if (lat_q != '1) begin
                  lat_q <= lat_q + 1'b1;
               end
            end
            pes_pkg::LS_RET: begin
               if (tag_cancel) begin
                  ld_st_q <= pes_pkg::LS_IDLE;
                  lat_q   <= 16'h0001;
               end else if (tag_retire) begin
                  ld_st_q <= pes_pkg::LS_IDLE;
                  lat_q   <= '0;
               end
            end
            default: ld_st_q <= pes_pkg::LS_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         last_addr_q <= 64'h0;
         last_src_q  <= 6'h0;
         last_lat_q  <= '0;
      end else if (tag_retire && !tag_cancel) begin
         last_addr_q <= ld_addr_i;
         last_src_q  <= {ld_lock_i, ld_second_tlb_miss_i, ld_src_i};
         last_lat_q  <= lat_q;
      end
   end

   // Counts regardless of reload value; the counter owns sampling cadence
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         latency_count_o <= 4'h0;
      end else begin
         latency_count_o <= (tag_retire && !tag_cancel && (lat_q > thr_q))
                            ? ll_ctr : 4'h0;
      end
   end

   AST_COUNT_ABOVE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (|latency_count_o) |-> $past(lat_q > thr_q) && $past(tag_retire))
      else $error("latency count without load above threshold");

   sequence s_cancel_tag;
      (ld_st_q != pes_pkg::LS_IDLE) && tag_cancel;
   endsequence
   AST_CANCEL_KEEPS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      s_cancel_tag |=> (ld_st_q == pes_pkg::LS_IDLE) && $stable(last_lat_q)
                       && (latency_count_o == 4'h0))
      else $error("cancelled load changed latency state");

   AST_GO_ENDS_MEAS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (ld_st_q == pes_pkg::LS_MEAS) && ld_go_i && (ld_go_id_i == tag_id_q) && !tag_cancel
      |=> (ld_st_q == pes_pkg::LS_RET) && (lat_q == $past(lat_q) + 1'b1))
      else $error("globally observed did not close measurement");

   // ***************************************************************
   // Sampling assists and record generation
   // ***************************************************************
   logic [3:0]  pend_q;
   logic        st_rdy_q;
   logic [63:0] st_addr_q;
   logic [5:0]  st_stat_q;
   logic [3:0]  arm;
   logic        ps_ctr;
   logic [3:0]  ready_req;
   logic [1:0]  push_ctr;
   logic        push_valid;
   logic        push_ready;
   logic        push;
   logic        push_ps;
   logic [63:0] push_addr;
   logic [63:0] push_src;
   logic [63:0] push_lat;
   logic [3:0]  clr_mask;

   assign arm       = ctr_ovf_i[3:0] & samp_en & ev_ok;
   assign ps_ctr    = ps_en && (event_select_i[3] == pes_pkg::PSTORE_EVENT);
   assign ready_req = {pend_q[3] && (!ps_ctr || st_rdy_q), pend_q[2:0]};

   always_comb begin
      push_ctr = 2'h0;
      for (int i = pes_pkg::NUM_PREC_CTR - 1; i >= 0; i--) begin
         if (ready_req[i]) begin
            push_ctr = 2'(i);
         end
      end
   end

   assign push_valid = |ready_req;
   assign push       = push_valid && push_ready;
   assign push_ps    = (push_ctr == pes_pkg::PSTORE_CTR) && ps_ctr;
   assign push_addr  = push_ps ? st_addr_q : last_addr_q;
   assign push_src   = push_ps ? 64'(st_stat_q)
                     : (lat_en[push_ctr] ? 64'(last_src_q) : 64'h0);
   assign push_lat   = (push_ps || !lat_en[push_ctr]) ? 64'h0 : 64'(last_lat_q);
   assign clr_mask   = push ? (gs_ovf_q[3:0] & samp_en) : 4'h0;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend_q <= 4'h0;
      end else begin
         pend_q <= (pend_q & ~(push ? (4'h1 << push_ctr) : 4'h0)) | arm;
      end
   end

   // Store path waits for the next store to retire after the overflow
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_rdy_q  <= 1'b0;
         st_addr_q <= 64'h0;
         st_stat_q <= 6'h0;
      end else if (push && push_ps) begin
         st_rdy_q <= 1'b0;
      end else if (pend_q[3] && ps_ctr && !st_rdy_q && st_retire_i) begin
         st_rdy_q  <= 1'b1;
         st_addr_q <= st_addr_i;
         st_stat_q <= {st_lock_i, st_second_tlb_miss_i, 3'h0, st_l1_hit_i};
      end
   end

   // Overflow set wins over any clear in the same cycle
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gs_ovf_q <= 8'h0;
         gs_buf_q <= 1'b0;
      end else begin
         gs_ovf_q <= (gs_ovf_q & ~{4'h0, clr_mask}
                      & ~((msr_wr_i && (msr_addr_i == pes_pkg::MSR_OVF_CLEAR))
                          ? msr_wdata_i[7:0] : 8'h0)) | ctr_ovf_i;
         if (push) begin
            gs_buf_q <= 1'b1;
         end else if (msr_wr_i && (msr_addr_i == pes_pkg::MSR_OVF_CLEAR)
                      && msr_wdata_i[pes_pkg::GS_BUF_OVF_BIT]) begin
            gs_buf_q <= 1'b0;
         end
      end
   end

   always_comb begin
      global_status_o                         = 64'h0;
      global_status_o[7:0]                    = gs_ovf_q;
      global_status_o[pes_pkg::GS_BUF_OVF_BIT] = gs_buf_q;
   end

   pes_fifo #(
      .WIDTH (pes_pkg::REC_W),
      .DEPTH (DEPTH)
   ) u_rec_fifo (
      .core_clk_i  (core_clk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (push_valid),
      .in_ready_o  (push_ready),
      .in_data_i   ({push_ctr, push_addr, push_src, push_lat}),
      .out_valid_o (rec_valid_o),
      .out_ready_i (rec_ready_i),
      .out_data_o  ({rec_ctr_o, rec_addr_o, rec_src_o, rec_lat_o})
   );

   AST_LOW_CTR_ONLY: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      |(pend_q & ~$past(pend_q)) |-> |$past(ctr_ovf_i[3:0] & samp_en))
      else $error("sample request without low counter overflow");

   AST_PSTORE_CTR3: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      push && push_ps |-> (push_ctr == pes_pkg::PSTORE_CTR) && ps_en && (push_lat == 64'h0))
      else $error("store record on wrong counter or nonzero latency");

   AST_DISTRIB_CTR1: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      $rose(pend_q[0]) |-> $past(event_select_i[0][7:0]) != pes_pkg::EV_RET_INST)
      else $error("precise distribution sampled off counter one");

   AST_LOAD_FIELDS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      push && !push_ps && lat_en[push_ctr]
      |-> (push_lat == 64'(last_lat_q)) && (push_src[63:6] == 58'h0))
      else $error("load record fields not from last tagged load");

   // A software clear in the same cycle may lower any bit, so it is left out
   sequence s_record_write;
      push ##0 !(|ctr_ovf_i[3:0])
      ##0 !(msr_wr_i && (msr_addr_i == pes_pkg::MSR_OVF_CLEAR));
   endsequence
   AST_STATUS_CLEAR: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      s_record_write |=> ((gs_ovf_q[3:0] & $past(gs_ovf_q[3:0] & samp_en)) == 4'h0)
                         && (gs_ovf_q[7:4] == $past(gs_ovf_q[7:4] | ctr_ovf_i[7:4]))
                         && gs_buf_q)
      else $error("record write did not update overflow status");

   AST_STORE_WAIT: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      pend_q[3] && ps_ctr && !st_rdy_q |-> push_ctr != pes_pkg::PSTORE_CTR || !push)
      else $error("store record written before a store retired");

endmodule

// >>> bench/pes_tb.sv
// Self-checking bench for the precise sampling unit
`timescale 1ns/1ps
`define NE @(negedge core_clk_i)
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
$display("ERROR %s expected %h seen %h", n, e, a); end end
module testbench;
   logic             core_clk_i = 1'b0;
   logic             arst_n_i = 1'b0;
   logic             msr_wr_i = 1'b0, msr_rd_i = 1'b0, rec_ready_i = 1'b0;
   logic [11:0]      msr_addr_i = 12'h000;
   logic [63:0]      msr_wdata_i = 64'h0, ld_addr_i = 64'h0, st_addr_i = 64'h0, rd;
   logic [3:0][15:0] event_select_i = '0;
   logic [7:0]       ctr_ovf_i = 8'h00;
   logic             ld_disp_i = 1'b0, ld_go_i = 1'b0, ld_cancel_i = 1'b0;
   logic             ld_retire_i = 1'b0, st_retire_i = 1'b0, st_l1_hit_i = 1'b1;
   logic             ld_second_tlb_miss_i = 1'b1, ld_lock_i = 1'b1;
   logic             st_second_tlb_miss_i = 1'b1, st_lock_i = 1'b0;
   logic [3:0]       ld_disp_id_i = 4'h0, ld_go_id_i = 4'h0, ld_cancel_id_i = 4'h0;
   logic [3:0]       ld_retire_id_i = 4'h0, ld_src_i = 4'h5, latency_count_o, seen;
   logic [63:0]      msr_rdata_o, global_status_o, rec_addr_o, rec_src_o, rec_lat_o;
   logic             msr_ack_o, rec_valid_o;
   logic [1:0]       rec_ctr_o;
   int               n_mismatch = 0, cmp_count = 0, cyc = 0, i, n;
   logic [1:0]       tc[10] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
   logic [15:0]      te[10] = '{16'h01c0, 16'h01c0, 16'h003c, 16'h01c2, 16'h01c4,
                                16'h01c5, 16'h01d0, 16'h01d1, 16'h01d2, 16'h02d4};
   logic             tx[10] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

   pes_sampling #(.DEPTH(16)) dut_u (.core_clk_i, .arst_n_i, .msr_wr_i, .msr_rd_i,
      .msr_addr_i, .msr_wdata_i, .msr_rdata_o, .msr_ack_o, .event_select_i, .ctr_ovf_i,
      .ld_disp_i, .ld_disp_id_i, .ld_go_i, .ld_go_id_i, .ld_cancel_i, .ld_cancel_id_i,
      .ld_retire_i, .ld_retire_id_i, .ld_addr_i, .ld_src_i, .ld_second_tlb_miss_i, .ld_lock_i,
      .st_retire_i, .st_addr_i, .st_l1_hit_i, .st_second_tlb_miss_i, .st_lock_i,
      .latency_count_o, .global_status_o, .rec_valid_o, .rec_ready_i, .rec_ctr_o,
      .rec_addr_o, .rec_src_o, .rec_lat_o);

   always #5 core_clk_i = ~core_clk_i;
   // Generous ceiling; the sequence needs under 3000 cycles
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // **********
   // Tasks
   // **********
   task automatic complete_run();
      $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic msr(input logic wr, input logic [11:0] a, input logic [63:0] d);
      msr_wr_i = wr;
      msr_rd_i = ~wr;
      msr_addr_i = a;
      msr_wdata_i = d;
      `NE;
      msr_wr_i = 1'b0;
      msr_rd_i = 1'b0;
      for (int k = 0; k < 3 && msr_ack_o !== 1'b1; k++) `NE;
      `CHK("ack", 1'b1, msr_ack_o)
      rd = msr_rdata_o;
      `NE;
   endtask
   // Dispatch, data observed after lat cycles, then retire or cancel
   task automatic load(input logic [3:0] id, input int lat, input logic [63:0] a, input logic c);
      ld_disp_i = 1'b1;
      ld_disp_id_i = id;
      `NE;
      ld_disp_i = 1'b0;
      repeat (lat - 1) `NE;
      ld_go_i = 1'b1;
      ld_go_id_i = id;
      `NE;
      ld_go_i = 1'b0;
      ld_retire_i = ~c;
      ld_cancel_i = c;
      ld_retire_id_i = id;
      ld_cancel_id_i = id;
      ld_addr_i = a;
      `NE;
      ld_retire_i = 1'b0;
      ld_cancel_i = 1'b0;
      seen |= latency_count_o;
      `NE;
   endtask
   task automatic ovf(input logic [7:0] v);
      ctr_ovf_i = v;
      `NE;
      ctr_ovf_i = 8'h00;
      repeat (3) `NE;
   endtask

   // **********
   // Tests
   // **********
   initial begin
      repeat (4) `NE;
      arst_n_i = 1'b1;
      msr(1'b0, pes_pkg::MSR_SAMPLING_ENABLE, 64'h0);
      `CHK("se_rst", pes_pkg::SE_RESET, rd)
      msr(1'b0, pes_pkg::MSR_LATENCY_THRESHOLD, 64'h0);
      `CHK("thr_rst", 64'h3, rd)
      msr(1'b1, pes_pkg::MSR_GLOBAL_STATUS, 64'hff);
      msr(1'b0, pes_pkg::MSR_GLOBAL_STATUS, 64'h0);
      `CHK("gs_ro", 64'h0, rd)
      msr(1'b0, 12'h0ff, 64'h0);
      `CHK("unmapped", 64'h0, rd)
      msr(1'b1, pes_pkg::MSR_SAMPLING_ENABLE, 64'h0000000100000001);
      msr(1'b0, pes_pkg::MSR_SAMPLING_ENABLE, 64'h0);
      `CHK("se_wr", 64'h0000000100000001, rd)
      msr(1'b1, pes_pkg::MSR_LATENCY_THRESHOLD, 64'h9);
      event_select_i[0] = pes_pkg::LATENCY_EVENT;
      seen = 4'h0;
      for (i = 0; i < 16; i++) load(4'(i), 9, 64'h1000, 1'b0);
      `CHK("lat_eq_thr", 4'h0, seen)
      // Tagging is random, so retry until one tagged load counts
      for (i = 0; i < 60 && seen == 4'h0; i++) load(4'(i), 10, 64'h7fff_1234_5678, 1'b0);
      `CHK("lat_cnt", 4'h1, seen)
      load(4'h6, 20, 64'hdead, 1'b1);
      ovf(8'h23);
      `CHK("gs", 64'h4000000000000022, global_status_o)
      `CHK("ctr", 2'h0, rec_ctr_o)
      `CHK("addr", 64'h7fff_1234_5678, rec_addr_o)
      `CHK("src", 64'h35, rec_src_o)
      `CHK("lat", 64'd10, rec_lat_o)
      rec_ready_i = 1'b1;
      `NE;
      rec_ready_i = 1'b0;
      `CHK("no_rec_hi", 1'b0, rec_valid_o)
      msr(1'b1, pes_pkg::MSR_OVF_CLEAR, 64'h40000000000000ff);
      `CHK("gs_clr", 64'h0, global_status_o)
      event_select_i = '0;
      msr(1'b1, pes_pkg::MSR_SAMPLING_ENABLE, 64'he);
      for (i = 0; i < 10; i++) begin
         event_select_i[tc[i]] = te[i];
         ovf(8'h01 << tc[i]);
         `CHK("ev_rec", tx[i], rec_valid_o)
         rec_ready_i = 1'b1;
         `NE;
         rec_ready_i = 1'b0;
         event_select_i = '0;
      end
      msr(1'b1, pes_pkg::MSR_SAMPLING_ENABLE, 64'h8000000000000008);
      event_select_i[3] = pes_pkg::PSTORE_EVENT;
      ovf(8'h08);
      `CHK("st_wait", 1'b0, rec_valid_o)
      st_addr_i = 64'h5a5a_0040;
      st_retire_i = 1'b1;
      `NE;
      st_retire_i = 1'b0;
      repeat (3) `NE;
      `CHK("st_ctr", 2'h3, rec_ctr_o)
      `CHK("st_addr", 64'h5a5a_0040, rec_addr_o)
      `CHK("st_stat", 64'h11, rec_src_o)
      `CHK("st_lat", 64'h0, rec_lat_o)
      rec_ready_i = 1'b1;
      `NE;
      rec_ready_i = 1'b0;
      msr(1'b1, pes_pkg::MSR_SAMPLING_ENABLE, 64'h4);
      event_select_i = '0;
      event_select_i[2] = 16'h01c2;
      for (i = 0; i < 20; i++) ovf(8'h04);
      // Full buffer keeps one request pending, pushed once room appears
      for (n = 0; n < 40 && rec_valid_o === 1'b1; n++) begin
         rec_ready_i = 1'b1;
         `NE;
      end
      rec_ready_i = 1'b0;
      `CHK("drained", 17, n)
      complete_run();
   end
endmodule
